// File: verilog/sas_serial_port.sv
// stereo converter control, calibration and serial port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - modulator sample clock is input clock halved
// - divided clock out stays at 128x rate
// - analog power-down high holds analog section down
// - digital power-down release starts 4096-period calibration
// - calibration flag rises on power-down, falls after
// - zero select routes modulators to zero inputs
// - role select picks master dividers or slave inputs
// - samples leave msb first, two's complement
// - overload and channel tags follow every word
// - launch edge polarity is a build option
// - master bit clock runs at 64x rate
// - slave shifts only while gate high, msb excepted
// - channel select edge one bit before gate
// - left while select high, msb one bit later
// - slave select rise starts left msb
// - both words of a period sampled together
// - master gate spans msb through audio lsb
// - slave low gate delays bits, msb still follows
// - zero during calibration, offset subtracted afterwards
// - dividers held in power-down, released on clock edge
module sas_serial_port
	import sas_pkg::*;
#(
	parameter bit LAUNCH_RISE = 1'b1, // data changes on bit clock rise
	parameter int CAL_PERIODS = SAS_CAL_PERIODS // calibration length
) (
	input wire logic pclk, // filter clock reference
	input wire logic presetn, // async reset, low active
	input wire logic ce, // clock enable, freezes all state
	input wire logic [11:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic digital_powerdown, // pin, high powers down
	input wire logic analog_powerdown, // pin, high powers down
	input wire logic zero_select_in, // pin, zero inputs select
	input wire logic modulator_clock_in, // pin, 128x clock
	input wire sas_sample_type sample_in, // filter output pair
	input wire logic sample_valid, // sample_in strobe
	output logic modulator_sample_clock, // halved modulator clock
	output logic divided_clock_out, // 128x clock
	output logic analog_hold, // analog section held down
	output logic modulator_zero_select, // modulators on zero inputs
	output logic cal_active_out, // calibration running
	output logic serial_out, // serial data
	input wire logic bit_clock_in, // bit clock pin level
	output logic bit_clock_out, // bit clock drive
	output logic bit_clock_oe_n, // low while driving
	input wire logic frame_gate_in, // frame gate pin level
	output logic frame_gate_out, // frame gate drive
	output logic frame_gate_oe_n, // low while driving
	input wire logic channel_select_in, // channel select pin level
	output logic channel_select_out, // channel select drive
	output logic channel_select_oe_n // low while driving
);
	logic [1:0] ctrl; // software control bits
	logic clock_ratio_select; // 384x filter clock when high
	logic port_role_select; // master when high
	logic [SAS_NPIN-1:0] pin_s1; // first stage, read by s2 only
	logic [SAS_NPIN-1:0] pin_s2; // second stage
	logic [SAS_NPIN-1:0] pin_s3; // third stage
	logic [SAS_NPIN-1:0] pin_q; // settled pin levels
	logic [SAS_NPIN-1:0] pin_prev; // settled levels one cycle ago
	sas_state_type state; // calibration sequencer
	logic [12:0] cal_cnt; // channel-select periods counted
	logic [SAS_WORD_BITS-1:0] ofs_left; // stored left offset
	logic [SAS_WORD_BITS-1:0] ofs_right; // stored right offset
	sas_sample_type pair; // pair latched for one period
	logic [1:0] dcnt; // divided clock counter
	logic [1:0] hcnt; // bit clock half counter
	logic m_bclk; // master bit clock
	logic [5:0] m_bit; // master bit position in period
	logic m_lr; // master channel select
	logic m_fg; // master frame gate
	logic lr_prev; // channel select before, for period count
	logic [SAS_SLOT_BITS-1:0] shreg; // outgoing slot
	logic [4:0] left_bits; // slot bits still to send
	logic pd; // settled digital power-down
	logic [1:0] div_top; // divided clock terminal
	logic [1:0] half_top; // half period terminal
	logic m_launch; // master launch edge this cycle
	logic [5:0] next_bit; // master bit after launch
	logic s_launch; // slave launch edge seen
	logic start; // msb load event
	logic advance; // shift event
	logic start_left; // loaded word is left
	logic cur_lr; // channel select in use
	logic [SAS_WORD_BITS-1:0] corr_left; // offset corrected left
	logic [SAS_WORD_BITS-1:0] corr_right; // offset corrected right
	logic addr_ok; // mapped address

	assign clock_ratio_select = ctrl[SAS_CTRL_RATIO];
	assign port_role_select = ctrl[SAS_CTRL_ROLE];
	assign pd = pin_q[SAS_P_DPD];

	// three-flop synchronisers; a level counts once s2 and s3 agree
	genvar gi;
	generate
		for (gi = 0; gi < SAS_NPIN; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
					pin_prev[gi] <= 1'b0;
				end else if (ce) begin
					pin_s1[gi] <= pin_raw(gi);
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					pin_prev[gi] <= pin_q[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin
						pin_q[gi] <= pin_s3[gi];
					end
				end
			end
		end
	endgenerate

	// pin selector for the synchroniser loop
	function automatic logic pin_raw(input int idx);
		logic v;
		v = 1'b0;
		case (idx)
			SAS_P_DPD: v = digital_powerdown;
			SAS_P_APD: v = analog_powerdown;
			SAS_P_ZERO: v = zero_select_in;
			SAS_P_BCLK: v = bit_clock_in;
			SAS_P_FG: v = frame_gate_in;
			SAS_P_LR: v = channel_select_in;
			SAS_P_MOD: v = modulator_clock_in;
			default: v = 1'b0;
		endcase
		return v;
	endfunction : pin_raw

	// analog side controls, registered from settled pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_hold <= 1'b1;
			modulator_zero_select <= 1'b0;
			modulator_sample_clock <= 1'b0;
		end else if (ce) begin
			analog_hold <= pin_q[SAS_P_APD];
			modulator_zero_select <= pin_q[SAS_P_ZERO];
			// toggle on each rise halves the modulator clock
			if (pin_q[SAS_P_MOD] && !pin_prev[SAS_P_MOD]) begin
				modulator_sample_clock <= !modulator_sample_clock;
			end
		end
	end

	// ratio dependent terminals, host supplies the matching clock
	assign div_top = clock_ratio_select ? SAS_DIV_HIGH : SAS_DIV_LOW;
	assign half_top = clock_ratio_select ? SAS_HALF_HIGH : SAS_HALF_LOW;

	// divided clock, 128x whichever ratio; held in power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dcnt <= 2'h0;
			divided_clock_out <= 1'b0;
		end else if (ce) begin
			if (pd) begin
				dcnt <= 2'h0;
				divided_clock_out <= 1'b0;
			end else begin
				dcnt <= (dcnt == div_top - 2'h1) ? 2'h0 : dcnt + 2'h1;
				divided_clock_out <= (dcnt == 2'h0);
			end
		end
	end

	// master launch: half period ends on the chosen edge
	assign m_launch = (hcnt == half_top - 2'h1) && (m_bclk != LAUNCH_RISE);
	assign next_bit = m_bit + 6'h01;

	// master dividers: bit clock, bit position, select, gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcnt <= 2'h0;
			m_bclk <= 1'b0;
			m_bit <= SAS_BIT_LAST;
			m_lr <= 1'b0;
			m_fg <= 1'b0;
		end else if (ce) begin
			if (pd || !port_role_select) begin
				// reset while down so several parts restart together
				hcnt <= 2'h0;
				m_bclk <= 1'b0;
				m_bit <= SAS_BIT_LAST;
				m_lr <= 1'b0;
				m_fg <= 1'b0;
			end else begin
				if (hcnt == half_top - 2'h1) begin
					hcnt <= 2'h0;
					m_bclk <= !m_bclk;
				end else begin
					hcnt <= hcnt + 2'h1;
				end
				if (m_launch) begin
					m_bit <= next_bit;
					// left half while bit position below 32
					m_lr <= !next_bit[5];
					// gate covers msb through audio lsb
					m_fg <= (next_bit[4:0] >= SAS_MSB_POS) && (next_bit[4:0] <= SAS_LSB_POS);
				end
			end
		end
	end

	// slave launch edge from settled bit clock
	assign s_launch = LAUNCH_RISE ? (pin_q[SAS_P_BCLK] && !pin_prev[SAS_P_BCLK])
		: (!pin_q[SAS_P_BCLK] && pin_prev[SAS_P_BCLK]);

	// load and shift events for both roles
	always_comb begin
		if (port_role_select) begin
			// msb goes out one bit after the select edge
			start = m_launch && (next_bit[4:0] == SAS_MSB_POS);
			advance = m_launch && !start;
			start_left = !next_bit[5];
		end else begin
			// select change presents msb whatever the gate does
			start = pin_q[SAS_P_LR] != pin_prev[SAS_P_LR];
			advance = s_launch && pin_q[SAS_P_FG] && !start;
			start_left = pin_q[SAS_P_LR];
		end
	end

	// channel select in use, for counting calibration periods
	assign cur_lr = port_role_select ? m_lr : pin_q[SAS_P_LR];

	// calibration sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SAS_PD;
			cal_cnt <= 13'h0000;
			lr_prev <= 1'b0;
		end else if (ce) begin
			lr_prev <= cur_lr;
			case (state)
				SAS_PD: begin
					cal_cnt <= 13'h0000;
					if (!pd) begin
						state <= SAS_CAL;
					end
				end
				SAS_CAL: begin
					if (pd) begin
						state <= SAS_PD;
					end else if (cur_lr && !lr_prev) begin
						// first rise opens the count, each later rise closes a period
						if (cal_cnt == 13'(CAL_PERIODS)) begin
							state <= SAS_RUN;
						end
						cal_cnt <= cal_cnt + 13'h0001;
					end
				end
				SAS_RUN: begin
					if (pd) begin
						state <= SAS_PD;
					end
				end
				default: state <= SAS_PD;
			endcase
		end
	end

	// flag is up in power-down and through calibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_active_out <= 1'b1;
		end else if (ce) begin
			cal_active_out <= pd || (state != SAS_RUN);
		end
	end

	// offsets: last sample seen during calibration is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ofs_left <= '0;
			ofs_right <= '0;
		end else if (ce) begin
			if (state == SAS_CAL && !pd && sample_valid) begin
				ofs_left <= sample_in.left;
				ofs_right <= sample_in.right;
			end
		end
	end

	// wraps modulo 2^16, like the stored word it came from
	assign corr_left = sample_in.left - ofs_left;
	assign corr_right = sample_in.right - ofs_right;

	// pair latched at each left start so both words match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair <= '0;
		end else if (ce) begin
			if (start && start_left) begin
				if (cal_active_out) begin
					pair <= '0;
				end else begin
					pair <= '{left: corr_left, right: corr_right,
						ovl_left: sample_in.ovl_left,
						ovl_right: sample_in.ovl_right};
				end
			end
		end
	end

	// slot shifter: word msb first, then overload, then channel tag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg <= '0;
			left_bits <= 5'h00;
		end else if (ce) begin
			if (pd) begin
				shreg <= '0;
				left_bits <= 5'h00;
			end else if (start) begin
				left_bits <= SAS_SLOT_LEN;
				if (cal_active_out) begin
					// both channels zero, even a right slot first after release
					shreg <= {{SAS_WORD_BITS{1'b0}}, 1'b0, start_left};
				end else if (!start_left) begin
					shreg <= {pair.right, pair.ovl_right, 1'b0};
				end else begin
					// left word leaves with the pair being latched
					shreg <= {corr_left, sample_in.ovl_left, 1'b1};
				end
			end else if (advance && left_bits != 5'h00) begin
				shreg <= {shreg[SAS_SLOT_BITS-2:0], 1'b0};
				left_bits <= left_bits - 5'h01;
			end
		end
	end

	// serial line and pin drives; oe low while this end drives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_out <= 1'b0;
			bit_clock_out <= 1'b0;
			frame_gate_out <= 1'b0;
			channel_select_out <= 1'b0;
			bit_clock_oe_n <= 1'b1;
			frame_gate_oe_n <= 1'b1;
			channel_select_oe_n <= 1'b1;
		end else if (ce) begin
			serial_out <= (left_bits != 5'h00) && shreg[SAS_SLOT_BITS-1];
			bit_clock_out <= m_bclk;
			frame_gate_out <= m_fg;
			channel_select_out <= m_lr;
			bit_clock_oe_n <= !port_role_select;
			frame_gate_oe_n <= !port_role_select;
			channel_select_oe_n <= !port_role_select;
		end
	end

	// apb slave: zero wait, read data set up in the setup phase
	assign addr_ok = (paddr == SAS_ADDR_CTRL) || (paddr == SAS_ADDR_STAT)
		|| (paddr == SAS_ADDR_OFSL) || (paddr == SAS_ADDR_OFSR);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// control register write, full word at access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= SAS_CTRL_RESET;
		end else if (ce) begin
			if (psel && penable && pwrite && paddr == SAS_ADDR_CTRL) begin
				ctrl <= pwdata[1:0];
			end
		end
	end

	// read mux, registered; unmapped reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (ce) begin
			if (psel && !penable && !pwrite) begin
				prdata <= '0;
				case (paddr)
					SAS_ADDR_CTRL: prdata[1:0] <= ctrl;
					SAS_ADDR_STAT: begin
						prdata[SAS_STAT_CAL] <= cal_active_out;
						prdata[SAS_STAT_PD] <= pd;
					end
					SAS_ADDR_OFSL: prdata[SAS_WORD_BITS-1:0] <= ofs_left;
					SAS_ADDR_OFSR: prdata[SAS_WORD_BITS-1:0] <= ofs_right;
					default: prdata <= '0;
				endcase
			end
		end
	end

	// checks
	property p_pd_cal;
		@(posedge pclk) disable iff (!presetn)
		ce && pd |=> cal_active_out;
	endproperty
	a_pd_cal: assert property (p_pd_cal) else $error("cal flag low in power-down");

	property p_pd_div;
		@(posedge pclk) disable iff (!presetn)
		ce && pd |=> !divided_clock_out && m_bit == SAS_BIT_LAST;
	endproperty
	a_pd_div: assert property (p_pd_div) else $error("divider ran in power-down");

	property p_lr_gate;
		@(posedge pclk) disable iff (!presetn)
		ce && $changed(m_lr) |-> !m_fg;
	endproperty
	a_lr_gate: assert property (p_lr_gate) else $error("select edge with gate high");

	property p_msb_gate;
		@(posedge pclk) disable iff (!presetn)
		ce && port_role_select && start |=> m_fg && left_bits == SAS_SLOT_LEN;
	endproperty
	a_msb_gate: assert property (p_msb_gate) else $error("msb without gate");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		ce && !port_role_select && !pd && !start && !pin_q[SAS_P_FG] |=> $stable(shreg);
	endproperty
	a_hold: assert property (p_hold) else $error("shifted with gate low");

	property p_tag;
		@(posedge pclk) disable iff (!presetn)
		ce && !pd && start |=> shreg[0] == $past(start_left);
	endproperty
	a_tag: assert property (p_tag) else $error("channel tag wrong");

	property p_cal_zero;
		@(posedge pclk) disable iff (!presetn)
		ce && !pd && start && cal_active_out |=> shreg[SAS_SLOT_BITS-1:SAS_TAG_BITS] == '0;
	endproperty
	a_cal_zero: assert property (p_cal_zero) else $error("nonzero word in calibration");

	property p_modclk;
		@(posedge pclk) disable iff (!presetn)
		ce && pin_q[SAS_P_MOD] && !pin_prev[SAS_P_MOD] |=> $changed(modulator_sample_clock);
	endproperty
	a_modclk: assert property (p_modclk) else $error("modulator clock not halved");

	property p_run_flag;
		@(posedge pclk) disable iff (!presetn)
		ce && state == SAS_RUN && !pd |=> !cal_active_out;
	endproperty
	a_run_flag: assert property (p_run_flag) else $error("flag high after calibration");
endmodule : sas_serial_port
`default_nettype wire

// File: pkg/sas_pkg.sv
// constants and types for the stereo converter serial port
package sas_pkg;
	// apb byte addresses
	localparam logic [11:0] SAS_ADDR_CTRL = 12'h000;
	localparam logic [11:0] SAS_ADDR_STAT = 12'h004;
	localparam logic [11:0] SAS_ADDR_OFSL = 12'h008;
	localparam logic [11:0] SAS_ADDR_OFSR = 12'h00c;
	// control field positions
	localparam int SAS_CTRL_RATIO = 0;
	localparam int SAS_CTRL_ROLE = 1;
	localparam logic [1:0] SAS_CTRL_RESET = 2'h2;
	// status field positions
	localparam int SAS_STAT_CAL = 0;
	localparam int SAS_STAT_PD = 1;
	// filter clocks per divided clock: 256x and 384x against 128x
	localparam logic [1:0] SAS_DIV_LOW = 2'h2;
	localparam logic [1:0] SAS_DIV_HIGH = 2'h3;
	// bit clock half periods in filter clocks: 256/64/2 and 384/64/2
	localparam logic [1:0] SAS_HALF_LOW = 2'h2;
	localparam logic [1:0] SAS_HALF_HIGH = 2'h3;
	// serial slot layout
	localparam int SAS_WORD_BITS = 16;
	localparam int SAS_TAG_BITS = 2;
	localparam int SAS_SLOT_BITS = SAS_WORD_BITS + SAS_TAG_BITS;
	localparam logic [4:0] SAS_SLOT_LEN = 5'h12;
	localparam logic [4:0] SAS_MSB_POS = 5'h01;
	localparam logic [4:0] SAS_LSB_POS = 5'h10;
	localparam logic [5:0] SAS_BIT_LAST = 6'h3f;
	localparam int SAS_CAL_PERIODS = 4096;
	// synchronised pin indices
	localparam int SAS_NPIN = 7;
	localparam int SAS_P_DPD = 0;
	localparam int SAS_P_APD = 1;
	localparam int SAS_P_ZERO = 2;
	localparam int SAS_P_BCLK = 3;
	localparam int SAS_P_FG = 4;
	localparam int SAS_P_LR = 5;
	localparam int SAS_P_MOD = 6;
	// one converted sample pair from the filter
	typedef struct packed {
		logic [SAS_WORD_BITS-1:0] left;
		logic [SAS_WORD_BITS-1:0] right;
		logic ovl_left;
		logic ovl_right;
	} sas_sample_type;
	// calibration sequencer
	typedef enum logic [1:0] {
		SAS_PD = 2'b00,
		SAS_CAL = 2'b01,
		SAS_RUN = 2'b10
	} sas_state_type;
endpackage : sas_pkg

// File: test/sas_rx_model.sv
// serial receiver and slave timing source facing the port
`timescale 1ns/1ps
`default_nettype none
module sas_rx_model
	import sas_pkg::*;
(
	input wire logic pclk, // filter clock
	input wire logic presetn, // async reset, low
	input wire logic slave, // we make the timing
	input wire logic [4:0] gate_delay, // bits the gate stays low
	input wire logic sdat, // serial data line
	input wire logic bclk, // bit clock line
	input wire logic gate, // frame gate line
	input wire logic sel, // channel select line
	output logic bclk_drv, // bit clock we drive
	output logic gate_drv, // gate we drive
	output logic sel_drv, // select we drive
	output logic [15:0] word, // last word shifted in
	output logic ovl, // overload tag
	output logic tag, // channel tag
	output logic left, // select level of the slot
	output logic gate_ok, // gate matched each bit, checked as master only
	output int words // completed words
);
	logic [9:0] g; // our divider on the filter clock
	logic pb; // last bit clock
	logic ps; // last select
	logic cur; // select of this slot
	logic [4:0] cnt; // bits taken so far
	logic [4:0] idx; // index of the bit now taken
	assign idx = cnt + 5'h01;
	// slow 16-clock bits: the port resyncs our pins
	// when not ours the lines toggle, so stale levels never look valid
	assign bclk_drv = slave ? g[3] : g[0];
	assign sel_drv = slave ? ~g[9] : g[1];
	// gate moves on falls, low for the delay
	assign gate_drv = slave ? (g[8:4] >= gate_delay) : g[2];
	// sample on fall as master, on rise before the shift as slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g <= 10'h000;
			pb <= 1'b0;
			ps <= 1'b0;
			cnt <= 5'h13;
			words <= 0;
		end else begin
			g <= g + 10'h001;
			pb <= bclk;
			ps <= sel;
			if (sel != ps) begin // slot opens, msb is next as slave
				cnt <= slave ? 5'h01 : 5'h00;
				cur <= sel;
				gate_ok <= 1'b1;
			end else if (cnt < 5'h13 && (slave ? bclk && !pb && gate : !bclk && pb)) begin
				cnt <= idx;
				if (idx >= 5'h02 && idx <= 5'h11) word <= {word[14:0], sdat};
				if (idx == 5'h12) ovl <= sdat;
				if (idx == 5'h13) begin // second tag closes the word
					tag <= sdat;
					left <= cur;
					words <= words + 1;
				end
				if (!slave && gate != (idx >= 5'h02 && idx <= 5'h11)) gate_ok <= 1'b0;
			end
		end
	end
endmodule : sas_rx_model
`default_nettype wire

// File: test/tb_sas_serial_port.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module tb_sas_serial_port;
	import sas_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1; // ce tied: no freeze
	logic [11:0] paddr = 12'h0; // apb address
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
	logic [31:0] pwdata = 32'h0, prdata, q; // apb data
	logic pready, pslverr, e; // apb answer
	logic digital_powerdown = 1'b0, analog_powerdown = 1'b0; // pins
	logic zero_select_in = 1'b0, modulator_clock_in = 1'b0; // pins
	sas_sample_type sample_in = '0; // filter pair
	logic sample_valid = 1'b0; // filter strobe
	logic [5:0] vc = 6'h0; // strobe spacing
	logic modulator_sample_clock, divided_clock_out, analog_hold, modulator_zero_select;
	logic cal_active_out, serial_out, bit_clock_out, bit_clock_oe_n, frame_gate_out;
	logic frame_gate_oe_n, channel_select_out, channel_select_oe_n; // pin drives
	logic bclk_drv, gate_drv, sel_drv, bclk_w, gate_w, sel_w; // shared lines
	logic slave = 1'b0; // model makes the timing
	logic [4:0] gate_delay = 5'h03; // slave gate low bits
	logic [15:0] word; // received word
	logic ovl, tag, left, gate_ok; // received tags
	int words, bad_count = 0, comparisons = 0, t; // counters
	time t0; // calibration start
	logic [3:0] mon_now, mon_prev = 4'h0; // watched clocks
	int mon_cnt[4] = '{0, 0, 0, 0}, mon_per[4] = '{0, 0, 0, 0}; // rise spacing
	// each line carries whoever has its enable low
	assign bclk_w = bit_clock_oe_n ? bclk_drv : bit_clock_out;
	assign gate_w = frame_gate_oe_n ? gate_drv : frame_gate_out;
	assign sel_w = channel_select_oe_n ? sel_drv : channel_select_out;
	assign mon_now = {modulator_sample_clock, channel_select_out, bit_clock_out, divided_clock_out};
	sas_serial_port #(.CAL_PERIODS(4)) sas_serial_port_i (.pclk, .presetn, .ce, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .digital_powerdown,
		.analog_powerdown, .zero_select_in, .modulator_clock_in, .sample_in, .sample_valid,
		.modulator_sample_clock, .divided_clock_out, .analog_hold, .modulator_zero_select,
		.cal_active_out, .serial_out, .bit_clock_in(bclk_w), .bit_clock_out, .bit_clock_oe_n,
		.frame_gate_in(gate_w), .frame_gate_out, .frame_gate_oe_n, .channel_select_in(sel_w),
		.channel_select_out, .channel_select_oe_n);
	sas_rx_model sas_rx_model_i (.pclk, .presetn, .slave, .gate_delay, .sdat(serial_out),
		.bclk(bclk_w), .gate(gate_w), .sel(sel_w), .bclk_drv, .gate_drv, .sel_drv, .word,
		.ovl, .tag, .left, .gate_ok, .words);
	// 25 MHz filter clock
	initial forever #20 pclk = ~pclk;
	// modulator clock far below pclk, as the pin sampler needs
	initial forever begin
		repeat (8) @(posedge pclk);
		modulator_clock_in <= ~modulator_clock_in;
	end
	// one filter strobe every 64 clocks, spacing between rises
	always @(posedge pclk) begin
		vc <= vc + 6'h01;
		sample_valid <= (vc == 6'h00);
		mon_prev <= mon_now;
		for (int i = 0; i < 4; i++) begin
			mon_cnt[i] <= mon_cnt[i] + 1;
			if (mon_now[i] && !mon_prev[i]) begin
				mon_per[i] <= mon_cnt[i] + 1;
				mon_cnt[i] <= 0;
			end
		end
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask : check
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0, q, e);
		check(n, q, x);
	endtask : rd
	// bounded wait for the calibration flag to drop
	task automatic wait_cal();
		int n;
		n = 0;
		while (cal_active_out !== 1'b0 && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		check("cal_end", n < 5000, 1'b1);
	endtask : wait_cal
	// next received word of one channel
	task automatic expect_word(input logic want, input logic [15:0] w, input logic o);
		int w0;
		int n;
		w0 = words;
		n = 0;
		while (!(words != w0 && left === want) && n < 6000) begin
			@(posedge pclk);
			n++;
		end
		check("word_wait", n < 6000, 1'b1);
		check("word", {16'h0, word}, {16'h0, w});
		check("ovl_tag", ovl, o);
		check("chan_tag", tag, want);
		check("gate", gate_ok, 1'b1);
	endtask : expect_word
	task automatic periods(input int b, input int d, input int s);
		repeat (900) @(posedge pclk);
		check("oe_master", {bit_clock_oe_n, frame_gate_oe_n, channel_select_oe_n}, 3'h0);
		check("dclk_per", 32'(mon_per[0]), 32'(d));
		check("bclk_per", 32'(mon_per[1]), 32'(b));
		check("sel_per", 32'(mon_per[2]), 32'(s));
		check("mod_per", 32'(mon_per[3]), 32'h20);
	endtask : periods
	// offset-corrected left then right, after the new pair settles
	task automatic traffic();
		repeat (600) @(posedge pclk);
		expect_word(1'b1, 16'h1234 - 16'h0010, 1'b1);
		expect_word(1'b0, 16'h8001 - 16'h0020, 1'b0);
	endtask : traffic
	task automatic report_and_stop();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		check("cal_rst", cal_active_out, 1'b1);
		rd(SAS_ADDR_CTRL, 32'(SAS_CTRL_RESET), "ctrl_rst");
		apb(1'b0, 12'h010, 32'h0, q, e);
		check("unmapped_err", e, 1'b1);
		check("unmapped_data", q, 32'h0);
		for (int v = 1; v >= 0; v--) begin // pins high, then back low
			analog_powerdown <= v[0];
			zero_select_in <= v[0];
			repeat (6) @(posedge pclk);
			check("analog_hold", analog_hold, v[0]);
			check("zero_sel", modulator_zero_select, v[0]);
		end
		wait_cal();
		periods(4, 2, 256);
		$display("test reset_master done");
		// power-down pulse with a steady pair to be stored
		sample_in <= {16'h0010, 16'h0020, 2'b00};
		digital_powerdown <= 1'b1;
		repeat (6) @(posedge pclk);
		check("cal_pd", cal_active_out, 1'b1);
		check("dclk_pd", divided_clock_out, 1'b0);
		rd(SAS_ADDR_STAT, 32'h3, "stat_pd");
		digital_powerdown <= 1'b0;
		t0 = $time;
		expect_word(1'b0, 16'h0000, 1'b0);
		expect_word(1'b1, 16'h0000, 1'b0);
		wait_cal();
		t = int'(($time - t0) / 40);
		// four full select periods of 256 clocks, plus pin latency
		check("cal_len", t >= 1024 && t < 1300, 1'b1);
		rd(SAS_ADDR_OFSL, 32'h10, "ofs_l");
		rd(SAS_ADDR_OFSR, 32'h20, "ofs_r");
		sample_in <= {16'h1234, 16'h8001, 2'b10};
		traffic();
		$display("test calibration done");
		apb(1'b1, SAS_ADDR_CTRL, 32'h3, q, e);
		rd(SAS_ADDR_CTRL, 32'h3, "ctrl_384");
		periods(6, 3, 384);
		traffic();
		$display("test ratio_384 done");
		// slave role: our lines drive the port, gate held low first
		apb(1'b1, SAS_ADDR_CTRL, 32'h0, q, e);
		slave <= 1'b1;
		repeat (4) @(posedge pclk);
		check("oe_slave", {bit_clock_oe_n, frame_gate_oe_n, channel_select_oe_n}, 3'h7);
		traffic();
		gate_delay <= 5'h00;
		traffic();
		$display("test slave done");
		report_and_stop();
	end
	// about 10000 clocks of tests; cut a hang well beyond
	initial begin
		#1600000;
		bad_count++;
		$display("ERROR watchdog expected finish seen hang");
		report_and_stop();
	end
endmodule : tb_sas_serial_port
`default_nettype wire
